// File: common/dmas_consts.vh
// Constants for the display memory address sequencer
`ifndef DMAS_CONSTS_VH
`define DMAS_CONSTS_VH
`define DMAS_OFF_CMD      8'h00
`define DMAS_OFF_CTRL     8'h04
`define DMAS_OFF_STATUS   8'h08
`define DMAS_OFF_XPOS     8'h0C
`define DMAS_OFF_YPOS     8'h10
`define DMAS_OFF_SCAN     8'h14
`define DMAS_OFF_ID       8'h18
`define DMAS_CTRL_PEN     0
`define DMAS_CTRL_HSW     2
`define DMAS_CTRL_INK     1
`define DMAS_SCAN_FR_HI   2'd2
`define DMAS_SCAN_FR_LO   2'd1
`define DMAS_ST_READY     2
`define DMAS_ST_VBLANK    1
`define DMAS_ST_PERIOD0   3
`define DMAS_CMD_SCAN_A   8'h04
`define DMAS_CMD_SCAN_B   8'h06
`define DMAS_CMD_SCAN_C   8'h07
`define DMAS_CMD_SCAN_D   8'h0C
`define DMAS_CMD_DOT      8'h80
`define DMAS_LINES_REF    4
`define DMAS_REF_NORMAL   3
`define DMAS_REF_HSW      19
`define DMAS_DISP_LINES   256
`define DMAS_SEG_LAST     6'h3F
`define DMAS_SYNC_CYC     2
`define DMAS_RESP_OKAY    2'b00
`define DMAS_RESP_SLVERR  2'b10
`endif

// File: logic/dmas_sequencer.v
// Display memory access sequencer with AXI4-Lite register slave
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "dmas_consts.vh"
////////////////////////////////////////////////////////////////////////////
module dmas_sequencer #(
    parameter LINES_PER_FRAME = 312,
    parameter [31:0] ID_VALUE = 32'h0000_5A5A // arbitrary value
)(
    input wire clk_i,
    input wire resetn_i,
    input wire format_select_i,
    input wire forced_write_in_i,
    input wire [7:0] s_axi_awaddr_i,
    input wire s_axi_awvalid_i,
    output wire s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output wire s_axi_wready_o,
    output reg [1:0] s_axi_bresp_o,
    output reg s_axi_bvalid_o,
    input wire s_axi_bready_i,
    input wire [7:0] s_axi_araddr_i,
    input wire s_axi_arvalid_i,
    output wire s_axi_arready_o,
    output reg [31:0] s_axi_rdata_o,
    output reg [1:0] s_axi_rresp_o,
    output reg s_axi_rvalid_o,
    input wire s_axi_rready_i,
    output reg [6:0] mem_addr_lines_o,
    output reg [2:0] pixel_select_lines_o,
    output reg pixel_select_top_o,
    output reg x9_o,
    output reg blanking_out_o,
    output reg window_out_o,
    output reg dot_write_n_o,
    output reg pen_data_o,
    output reg memory_marker_out_o
);
    localparam ST_IDLE = 3'b001;
    localparam ST_SYNC = 3'b010;
    localparam ST_EXEC = 3'b100;
    localparam PH_DISP = 2'b00;
    localparam PH_WRITE = 2'b11;
    localparam PH_REF = 2'b10;

    ////////////////////////////////////////////////////////////////////////
    // Scan counters: phase toggles every clock (row/column halves)
    reg phase_q;
    reg [5:0] hseg_q;
    reg [8:0] vcnt_q;
    reg [8:0] line_q;
    reg [7:0] ctrl_q;
    reg [9:0] xpos_q;
    reg [8:0] ypos_q;
    reg [7:0] cmd_q;
    reg [2:0] state_q;
    reg [1:0] sync_cnt_q;
    reg [1:0] scan_frames_q;
    reg dot_pend_q;
    wire frame_end;
    wire line_end;

    assign line_end = phase_q && (hseg_q == `DMAS_SEG_LAST);
    assign frame_end = line_end && (line_q == LINES_PER_FRAME - 1);

    always @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            phase_q <= 1'b0;
            hseg_q <= 6'h00;
            vcnt_q <= 9'h000;
            line_q <= 9'h000;
        end
        else
        begin
            phase_q <= ~phase_q;
            if (phase_q)
                hseg_q <= hseg_q + 6'h01;
            if (line_end)
            begin
                // Bit 0 is parity, line count lives above it
                vcnt_q[8:1] <= vcnt_q[8:1] + 8'h01;
                line_q <= line_q + 9'h001;
            end
            if (frame_end)
            begin
                line_q <= 9'h000;
                vcnt_q[8:1] <= 8'h00;
                vcnt_q[0] <= ~vcnt_q[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame period scheduling
    reg [1:0] period;
    reg in_disp;
    reg in_ref;
    wire [8:0] blank_line;
    wire hsw;
    wire scanning;
    assign hsw = ctrl_q[`DMAS_CTRL_HSW];
    assign blank_line = line_q - 9'd`DMAS_DISP_LINES;
    assign scanning = (scan_frames_q != 2'b00);

    always @*
    begin
        in_disp = (line_q < `DMAS_DISP_LINES);
        if (hsw)
            // Refresh cycles spread over the first DMAS_REF_HSW * DMAS_LINES_REF (76) lines of the frame
            in_ref = (line_q < `DMAS_REF_HSW * `DMAS_LINES_REF);
        else
            in_ref = !in_disp &&
                (blank_line < `DMAS_REF_NORMAL * `DMAS_LINES_REF);
        // Scan beats forced write; forced write beats display and refresh, which beat other writes
        if (scanning)
            period = PH_DISP;
        else if (forced_write_in_i)
            period = PH_WRITE;
        else if (in_disp && !hsw)
            period = PH_DISP;
        else if (in_ref)
            period = PH_REF;
        else
            period = PH_WRITE;
    end

    ////////////////////////////////////////////////////////////////////////
    // Address multiplexing
    // Pin 0 carries the most significant bit of each half
    function [6:0] pin_order;
        input [6:0] v;
        integer i;
        begin
            for (i = 0; i < 7; i = i + 1)
                pin_order[i] = v[6 - i];
        end
    endfunction

    always @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            mem_addr_lines_o <= 7'h00;
            pixel_select_lines_o <= 3'h0;
            pixel_select_top_o <= 1'b1;
            x9_o <= 1'b0;
            blanking_out_o <= 1'b1;
            window_out_o <= 1'b0;
        end
        else
        begin
            // Forced write still shows the normal blanking outline
            blanking_out_o <= !(in_disp && !hsw) || scanning;
            window_out_o <= period[0];
            pixel_select_lines_o <= xpos_q[2:0];
            x9_o <= xpos_q[9];
            if (period == PH_WRITE)
            begin
                if (!phase_q)
                    mem_addr_lines_o <= pin_order({xpos_q[8:3],
                        format_select_i ? ypos_q[1] : ypos_q[0]});
                else if (format_select_i)
                    mem_addr_lines_o <=
                        pin_order({ypos_q[8:3], ypos_q[0]});
                else
                    mem_addr_lines_o <= pin_order(ypos_q[7:1]);
                pixel_select_top_o <= format_select_i ? ypos_q[2] : 1'b1;
            end
            else
            begin
                if (!phase_q)
                    mem_addr_lines_o <=
                        pin_order({hseg_q, vcnt_q[1]});
                else if (format_select_i)
                    mem_addr_lines_o <=
                        pin_order({vcnt_q[8:3], vcnt_q[0]});
                else
                    mem_addr_lines_o <=
                        pin_order(vcnt_q[8:2]);
                pixel_select_top_o <= format_select_i ? vcnt_q[2] : 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command synchroniser and write processor
    wire cmd_wr;

    always @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            state_q <= ST_IDLE;
            sync_cnt_q <= 2'b00;
            cmd_q <= 8'h00;
            scan_frames_q <= 2'b00;
            dot_pend_q <= 1'b0;
            dot_write_n_o <= 1'b1;
            pen_data_o <= 1'b0;
            memory_marker_out_o <= 1'b0;
        end
        else
        begin
            dot_write_n_o <= 1'b1;
            pen_data_o <= ctrl_q[`DMAS_CTRL_INK];
            memory_marker_out_o <= scanning;
            case (state_q)
            ST_IDLE:
                if (cmd_wr)
                begin
                    cmd_q <= s_axi_wdata_i[7:0];
                    sync_cnt_q <= 2'b01;
                    state_q <= ST_SYNC;
                end
            ST_SYNC:
                // Command decode lags the bus write by the sync cycles
                if (sync_cnt_q == `DMAS_SYNC_CYC - 1)
                begin
                    state_q <= ST_EXEC;
                    if ((hsw || forced_write_in_i) && is_cmd_scan(cmd_q))
                        scan_frames_q <= format_select_i ?
                            `DMAS_SCAN_FR_HI : `DMAS_SCAN_FR_LO;
                    else
                        dot_pend_q <= 1'b1;
                end
                else
                    sync_cnt_q <= sync_cnt_q + 2'b01;
            ST_EXEC:
            begin
                if (scanning && frame_end)
                    scan_frames_q <= scan_frames_q - 2'b01;
                // Dot strobe lands on a column half of a write period
                if (dot_pend_q && period == PH_WRITE && phase_q)
                begin
                    dot_pend_q <= 1'b0;
                    dot_write_n_o <= ~ctrl_q[`DMAS_CTRL_PEN];
                end
                if (!dot_pend_q && !scanning)
                    state_q <= ST_IDLE;
            end
            default:
                state_q <= ST_IDLE;
            endcase
        end
    end

    function is_cmd_scan;
        input [7:0] c;
        begin
            is_cmd_scan = (c == `DMAS_CMD_SCAN_A) ||
                (c == `DMAS_CMD_SCAN_B) || (c == `DMAS_CMD_SCAN_C) ||
                (c == `DMAS_CMD_SCAN_D);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave
    reg aw_q;
    reg w_q;
    reg [7:0] awaddr_q;
    reg [31:0] wdata_q;
    wire ready_bit;
    wire [31:0] status;
    assign ready_bit = (state_q == ST_IDLE);
    // Status bits: 3 write period, 2 ready, 1 blanking
    assign status = {28'h000_0000, period[0], ready_bit,
        !in_disp, 1'b0};
    assign s_axi_awready_o = !aw_q && !s_axi_bvalid_o;
    assign s_axi_wready_o = !w_q && !s_axi_bvalid_o;
    assign s_axi_arready_o = !s_axi_rvalid_o;
    wire aw_now = aw_q || (s_axi_awvalid_i && s_axi_awready_o);
    wire w_now = w_q || (s_axi_wvalid_i && s_axi_wready_o);
    wire [7:0] wa = aw_q ? awaddr_q : s_axi_awaddr_i;
    wire [31:0] wd = w_q ? wdata_q : s_axi_wdata_i;
    wire do_wr = aw_now && w_now && !s_axi_bvalid_o;
    // Host must not write a command while busy; such a command is dropped
    assign cmd_wr = do_wr && wa == `DMAS_OFF_CMD && ready_bit;

    always @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `DMAS_RESP_OKAY;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rresp_o <= `DMAS_RESP_OKAY;
            s_axi_rdata_o <= 32'h0000_0000;
            ctrl_q <= 8'h00;
            xpos_q <= 10'h000;
            ypos_q <= 9'h000;
        end
        else
        begin
            if (s_axi_awvalid_i && s_axi_awready_o)
            begin
                aw_q <= 1'b1;
                awaddr_q <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o)
            begin
                w_q <= 1'b1;
                wdata_q <= s_axi_wdata_i;
            end
            if (do_wr)
            begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= `DMAS_RESP_OKAY;
                case (wa)
                `DMAS_OFF_CMD: ;
                `DMAS_OFF_CTRL: ctrl_q <= wd[7:0];
                `DMAS_OFF_XPOS: xpos_q <= wd[9:0];
                `DMAS_OFF_YPOS: ypos_q <= wd[8:0];
                default: s_axi_bresp_o <= `DMAS_RESP_SLVERR;
                endcase
            end
            else if (s_axi_bvalid_o && s_axi_bready_i)
                s_axi_bvalid_o <= 1'b0;
            if (s_axi_arvalid_i && s_axi_arready_o)
            begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rresp_o <= `DMAS_RESP_OKAY;
                case (s_axi_araddr_i)
                `DMAS_OFF_CMD: s_axi_rdata_o <= {24'h00_0000, cmd_q};
                `DMAS_OFF_CTRL: s_axi_rdata_o <= {24'h00_0000, ctrl_q};
                `DMAS_OFF_STATUS: s_axi_rdata_o <= status;
                `DMAS_OFF_XPOS: s_axi_rdata_o <= {22'h00_0000, xpos_q};
                `DMAS_OFF_YPOS: s_axi_rdata_o <= {23'h00_0000, ypos_q};
                `DMAS_OFF_SCAN:
                    s_axi_rdata_o <= {17'h0_0000, vcnt_q, hseg_q};
                `DMAS_OFF_ID: s_axi_rdata_o <= ID_VALUE;
                default:
                begin
                    s_axi_rdata_o <= 32'h0000_0000;
                    s_axi_rresp_o <= `DMAS_RESP_SLVERR;
                end
                endcase
            end
            else if (s_axi_rvalid_o && s_axi_rready_i)
                s_axi_rvalid_o <= 1'b0;
        end
    end
    // Byte strobes ignored: each writable register takes its bits whatever the strobes
    wire unused_ok = |s_axi_wstrb_i;
endmodule

// File: verif/dmas_seq_chk.sv
// Port-level assertions for the display memory address sequencer
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
module dmas_seq_chk (
    input wire clk_i,
    input wire resetn_i,
    input wire format_select_i,
    input wire forced_write_in_i,
    input wire [7:0] s_axi_araddr_i,
    input wire s_axi_arvalid_i,
    input wire s_axi_arready_o,
    input wire s_axi_bready_i,
    input wire s_axi_bvalid_o,
    input wire [1:0] s_axi_rresp_o,
    input wire s_axi_rvalid_o,
    input wire pixel_select_top_o,
    input wire blanking_out_o,
    input wire window_out_o,
    input wire dot_write_n_o,
    input wire memory_marker_out_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
////////////////////////////////////////////////////////////////////////////
    a_period_code: assert property (
        !forced_write_in_i && !$past(forced_write_in_i)
        |-> blanking_out_o || !window_out_o)
        else $error("window pin high without blanking");
    a_forced_write: assert property (
        forced_write_in_i && $past(forced_write_in_i)
        && !memory_marker_out_o && !$past(memory_marker_out_o)
        |-> window_out_o || blanking_out_o)
        else $error("display period while write forced");
    a_top_fixed: assert property (
        !format_select_i && !$past(format_select_i) |-> pixel_select_top_o)
        else $error("top select low in narrow format");
    a_dot_pulse: assert property (
        $fell(dot_write_n_o) |=> dot_write_n_o)
        else $error("dot strobe longer than one cycle");
    a_dot_in_write: assert property (
        !dot_write_n_o |-> window_out_o
        && (blanking_out_o || $past(forced_write_in_i)))
        else $error("dot strobe outside a write period");
    a_bresp_done: assert property (
        s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
        else $error("write response repeated");
    a_rvalid_one: assert property (
        $rose(s_axi_rvalid_o)
        |-> $past(s_axi_arvalid_i) && $past(s_axi_arready_o))
        else $error("read data without an address");
    a_unmapped_rd: assert property (
        s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i > 8'h18
        |=> s_axi_rvalid_o && s_axi_rresp_o == 2'b10)
        else $error("unmapped read not refused");
endmodule

// File: verif/dmas_dram_model.sv
// Display memory plane model latching each dot write address
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
module dmas_dram_model (
    input wire clk_i,
    input wire [6:0] mem_addr_lines_i,
    input wire [2:0] pixel_select_lines_i,
    input wire pixel_select_top_i,
    input wire x9_i,
    input wire dot_write_n_i,
    output reg [13:0] addr_o,
    output reg [4:0] sel_o,
    output reg [1:0] chip_o,
    output reg [7:0] dots_o
);
    reg [6:0] prev_q;
    initial dots_o = 8'h00;
    always @(posedge clk_i)
    begin
        prev_q <= mem_addr_lines_i;
        // Row half sits on the lines the cycle before the column strobe
        if (!dot_write_n_i)
        begin
            addr_o <= {prev_q, mem_addr_lines_i};
            sel_o <= {x9_i, pixel_select_top_i, pixel_select_lines_i};
            chip_o <= pixel_select_lines_i[2:1];
            dots_o <= dots_o + 8'h01;
        end
    end
endmodule

// File: verif/tb_display_memory_address_sequencer.sv
// Self-checking bench for the display memory address sequencer
`timescale 1ns/1ns
`include "dmas_consts.vh"
////////////////////////////////////////////////////////////////////////////
module tb_display_memory_address_sequencer;
    localparam [31:0] ID = 32'h0000_1234; // Arbitrary value
    localparam integer REF_CYC = `DMAS_REF_NORMAL * `DMAS_LINES_REF * 2
        * (`DMAS_SEG_LAST + 1);
    localparam [31:0] SCANS = {`DMAS_CMD_SCAN_A, `DMAS_CMD_SCAN_B,
        `DMAS_CMD_SCAN_C, `DMAS_CMD_SCAN_D};
    reg clk_i = 1'b0;
    reg resetn_i = 1'b0;
    reg fmt = 1'b0;
    reg forced = 1'b0;
    reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    reg arvalid = 1'b0, rready = 1'b0;
    reg [7:0] awaddr = 8'h00, araddr = 8'h00;
    reg [31:0] wdata = 32'h0000_0000;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [6:0] mem_addr;
    wire [2:0] psel;
    wire top, x9, blank, win, dwn, pen, mark;
    wire [13:0] m_addr;
    wire [4:0] m_sel;
    wire [1:0] chip;
    wire [7:0] dots;
    reg [31:0] st, rx, ry;
    reg [1:0] rs;
    reg [7:0] n0;
    reg seen_mark;
    integer n_errors = 0, compares = 0, cnt_d = 0, cnt_r = 0, k, d0, r0;
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        if (!blank && !win)
            cnt_d <= cnt_d + 1;
        if (blank && !win)
            cnt_r <= cnt_r + 1;
    end
    dmas_sequencer #(.LINES_PER_FRAME(272), .ID_VALUE(ID)) dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .format_select_i(fmt),
        .forced_write_in_i(forced), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .mem_addr_lines_o(mem_addr),
        .pixel_select_lines_o(psel), .pixel_select_top_o(top), .x9_o(x9),
        .blanking_out_o(blank), .window_out_o(win), .dot_write_n_o(dwn),
        .pen_data_o(pen), .memory_marker_out_o(mark));
    dmas_dram_model mem (.clk_i(clk_i), .mem_addr_lines_i(mem_addr),
        .pixel_select_lines_i(psel), .pixel_select_top_i(top), .x9_i(x9),
        .dot_write_n_i(dwn), .addr_o(m_addr), .sel_o(m_sel), .chip_o(chip),
        .dots_o(dots));
////////////////////////////////////////////////////////////////////////////
    task chk(input [31:0] got, input [31:0] exp);
    begin
        compares = compares + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("unexpected at %0t: %h not %h", $time, got, exp);
        end
    end
    endtask
    // Local flags track the channels: the driven regs update only later
    task wr(input [7:0] a, input [31:0] d);
        integer i;
        reg aw_left;
        reg w_left;
        reg b_wait;
    begin
        @(posedge clk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_left = 1'b1;
        w_left = 1'b1;
        b_wait = 1'b1;
        for (i = 0; i < 200 && b_wait; i = i + 1)
        begin
            @(posedge clk_i);
            if (aw_left && awready)
            begin
                awvalid <= 1'b0;
                aw_left = 1'b0;
            end
            if (w_left && wready)
            begin
                wvalid <= 1'b0;
                w_left = 1'b0;
            end
            if (bvalid)
            begin
                rs = bresp;
                bready <= 1'b0;
                b_wait = 1'b0;
            end
        end
        chk(b_wait, 1'b0);
    end
    endtask
    task rd(input [7:0] a);
        integer i;
        reg ar_left;
        reg r_wait;
    begin
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        ar_left = 1'b1;
        r_wait = 1'b1;
        for (i = 0; i < 200 && r_wait; i = i + 1)
        begin
            @(posedge clk_i);
            if (ar_left && arready)
            begin
                arvalid <= 1'b0;
                ar_left = 1'b0;
            end
            if (rvalid)
            begin
                st = rdata;
                rs = rresp;
                rready <= 1'b0;
                r_wait = 1'b0;
            end
        end
        chk(r_wait, 1'b0);
    end
    endtask
    // Mid-run reset: reset levels first, then counters restart at zero
    task pulse_reset;
    begin
        @(posedge clk_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        chk({blank, win, dwn, top, mark}, 5'b10110);
        rd(`DMAS_OFF_SCAN);
        chk(st, 32'h0000_0001);
        rd(`DMAS_OFF_STATUS);
        chk(st[2], 1'b1);
    end
    endtask
    // Polls status; long bound because a dot may wait a whole frame
    task wait_ready;
        integer i;
    begin
        st = 32'h0;
        for (i = 0; i < 25000 && !st[2]; i = i + 1)
        begin
            rd(`DMAS_OFF_STATUS);
            seen_mark = seen_mark | mark;
        end
        chk(st[2], 1'b1);
    end
    endtask
    function [13:0] wexp(input [9:0] x, input [8:0] y, input f);
    begin
        wexp[13:7] = {f ? y[1] : y[0], x[3], x[4], x[5], x[6], x[7], x[8]};
        wexp[6:0] = f ? {y[0], y[3], y[4], y[5], y[6], y[7], y[8]}
            : {y[1], y[2], y[3], y[4], y[5], y[6], y[7]};
    end
    endfunction
    task dot(input [9:0] x, input [8:0] y, input slow);
    begin
        wr(`DMAS_OFF_XPOS, {22'h0, x});
        wr(`DMAS_OFF_YPOS, {23'h0, y});
        n0 = dots;
        wr(`DMAS_OFF_CMD, {24'h0, `DMAS_CMD_DOT});
        if (slow)
        begin
            rd(`DMAS_OFF_STATUS);
            chk(st[2], 1'b0);
            wr(`DMAS_OFF_CMD, {24'h0, `DMAS_CMD_DOT});
            chk(rs, `DMAS_RESP_OKAY);
        end
        wait_ready;
        chk(dots - n0, 1);
        chk(m_addr, wexp(x, y, fmt));
        chk(m_sel, {x[9], fmt ? y[2] : 1'b1, x[2:0]});
        chk(chip, x[2:1]);
        chk(pen, 1'b1);
    end
    endtask
    task end_sim;
    begin
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask
////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rx = $urandom(32'hc916_5320);
        repeat (20) @(posedge clk_i);
        resetn_i <= 1'b1;
        rd(`DMAS_OFF_ID);
        chk(st, ID);
        rd(`DMAS_OFF_STATUS);
        chk(st[2], 1'b1);
        rd(8'h40);
        chk(rs, `DMAS_RESP_SLVERR);
        wr(8'h44, 32'h0000_0001);
        chk(rs, `DMAS_RESP_SLVERR);
        $display("test registers done");
        wr(`DMAS_OFF_CTRL, 32'h0000_0003);
        d0 = cnt_d;
        r0 = cnt_r;
        dot(10'h2A5, 9'h15A, 1'b1);
        chk(cnt_d != d0, 1);
        chk(cnt_r - r0, REF_CYC);
        $display("test stalled dot done");
        forced <= 1'b1;
        for (k = 0; k < 8; k = k + 1)
        begin
            fmt <= k[0];
            rx = (k < 2) ? {32{k[0]}} : $urandom;
            ry = (k < 2) ? {32{k[0]}} : $urandom;
            dot(rx[9:0], ry[8:0], 1'b0);
        end
        $display("test forced dots done");
        fmt <= 1'b0;
        for (k = 0; k < 4; k = k + 1)
        begin
            seen_mark = 1'b0;
            wr(`DMAS_OFF_CMD, {24'h0, SCANS[8 * k +: 8]});
            if (k < 2)
                wait_ready;
            else
            begin
                // Later scans are cut by reset to bound the run
                rd(`DMAS_OFF_STATUS);
                seen_mark = mark;
                chk(st[2], 1'b0);
                pulse_reset;
            end
            chk(seen_mark, 1'b1);
        end
        $display("test scans done");
        forced <= 1'b0;
        wr(`DMAS_OFF_CTRL, 32'h0000_0007);
        repeat (2) @(posedge clk_i);
        d0 = cnt_d;
        r0 = cnt_r;
        repeat (4000) @(posedge clk_i);
        chk(cnt_d - d0, 0);
        chk(cnt_r != r0, 1);
        $display("test high speed done");
        end_sim;
    end
    initial
    begin
        #(50 * 90000);
        n_errors = n_errors + 1;
        end_sim;
    end
endmodule
bind dmas_sequencer dmas_seq_chk u_chk (.clk_i(clk_i), .resetn_i(resetn_i),
    .format_select_i(format_select_i), .forced_write_in_i(forced_write_in_i),
    .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o), .s_axi_bready_i(s_axi_bready_i),
    .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_rresp_o(s_axi_rresp_o),
    .s_axi_rvalid_o(s_axi_rvalid_o), .pixel_select_top_o(pixel_select_top_o),
    .blanking_out_o(blanking_out_o), .window_out_o(window_out_o),
    .dot_write_n_o(dot_write_n_o), .memory_marker_out_o(memory_marker_out_o));
